//--- hw/wdrf_watchdog.sv
// Watchdog timer with reset-source flags behind an APB slave.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module wdrf_watchdog
#(
	parameter int WDT_BASE_TICKS = wdrf_pkg::WDRF_BASE_TICKS
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [wdrf_pkg::WDRF_ADDR_W-1:0] paddr,
	input wire logic [wdrf_pkg::WDRF_DATA_W-1:0] pwdata,
	output logic [wdrf_pkg::WDRF_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic safetyFuse,
	input wire logic globalIrqEnable,
	input wire logic irqVectorTaken,
	input wire logic wdrStrobe,
	input wire logic brownoutReset,
	input wire logic pinReset,
	output logic wdtIrqReq,
	output logic wdtResetPulse,
	output logic wdtRunning
);
	import wdrf_pkg::*;

	logic oscTick;
	logic setupPhase;
	logic accessPhase;
	logic hitCsr;
	logic hitRss;
	logic wrCsr;
	logic wrRss;
	logic level2;
	logic wdeEff;
	logic running;
	logic timeout;
	logic irqAction;
	logic rstAction;
	logic chipReset;
	logic [3:0] selEff;
	logic [WDRF_CNT_W-1:0] limit;
	wdrf_mode_e mode;

	logic wdifR;
	logic wdifNxt;
	logic wdieR;
	logic wdieNxt;
	logic wdceR;
	logic wdceNxt;
	logic wdeR;
	logic wdeNxt;
	logic [2:0] ceCntR;
	logic [2:0] ceCntNxt;
	logic [3:0] pselR;
	logic [3:0] pselNxt;
	logic [3:0] rssR;
	logic [3:0] rssNxt;
	logic [WDRF_CNT_W-1:0] cntR;
	logic [WDRF_CNT_W-1:0] cntNxt;
	logic rstPulseR;
	logic rstPulseNxt;
	logic [WDRF_DATA_W-1:0] prdataR;
	logic [WDRF_DATA_W-1:0] prdataNxt;
	logic [7:0] csrView;

	// ****************************************
	// Oscillator tick.
	// ****************************************
	// oscillator tick enable.
	wdrf_tick_gen #(
		.ACC_W(WDRF_ACC_W),
		.STEP(WDRF_OSC_KHZ),
		.MODULUS(WDRF_CLK_KHZ)
	) u_tick (
		.clk(clk),
		.reset_n(reset_n),
		.tick(oscTick)
	);

	// ****************************************
	// Bus decode.
	// ****************************************
	always_comb
	begin
		hitCsr = 1'b0;
		hitRss = 1'b0;
		if (paddr == WDRF_CSR_ADDR)
		begin
			hitCsr = 1'b1;
		end
		else if (paddr == WDRF_RSS_ADDR)
		begin
			hitRss = 1'b1;
		end
	end

	assign setupPhase = psel & ~penable;
	assign accessPhase = psel & penable;
	assign wrCsr = accessPhase & pwrite & hitCsr;
	assign wrRss = accessPhase & pwrite & hitRss;
	assign pready = 1'b1;
	assign pslverr = accessPhase & ~hitCsr & ~hitRss;

	// ****************************************
	// Mode and time-out.
	// ****************************************
	// fuse picks level.
	assign level2 = safetyFuse;
	assign wdeEff = level2 | wdeR | rssR[WDRF_WDR_BIT];

	always_comb
	begin
		if (wdeEff && wdieR)
		begin
			mode = MODE_IRQ_RESET;
		end
		else if (wdieR)
		begin
			mode = MODE_IRQ;
		end
		else if (wdeEff)
		begin
			mode = MODE_RESET;
		end
		else
		begin
			mode = MODE_STOP;
		end
	end

	assign running = (mode != MODE_STOP);
	assign selEff = (pselR > WDRF_PSEL_MAX) ? WDRF_PSEL_MAX : pselR;
	assign limit = WDRF_CNT_W'(WDT_BASE_TICKS) << selEff;
	assign timeout = running & oscTick & (cntR == limit - WDRF_CNT_W'(1));
	assign irqAction = timeout & (mode == MODE_IRQ || mode == MODE_IRQ_RESET);
	assign rstAction = timeout & (mode == MODE_RESET);
	assign chipReset = brownoutReset | pinReset | rstPulseR;

	// ****************************************
	// Next state of registers and counter.
	// ****************************************
	always_comb
	begin
		wdifNxt = wdifR;
		wdieNxt = wdieR;
		wdceNxt = wdceR;
		wdeNxt = wdeR;
		ceCntNxt = ceCntR;
		pselNxt = pselR;
		rssNxt = rssR;
		cntNxt = cntR;
		rstPulseNxt = rstAction;
		if (chipReset)
		begin
			wdifNxt = 1'b0;
			wdieNxt = 1'b0;
			wdceNxt = 1'b0;
			wdeNxt = 1'b0;
			ceCntNxt = '0;
			pselNxt = WDRF_PSEL_RESET;
		end
		else
		begin
			if (wdceR)
			begin
				ceCntNxt = ceCntR - 3'h1;
				if (ceCntR == 3'h1)
				begin
					wdceNxt = 1'b0;
				end
			end
			if (wrCsr)
			begin
				if (pwdata[WDRF_CE_BIT] && pwdata[WDRF_EN_BIT])
				begin
					wdceNxt = 1'b1;
					ceCntNxt = WDRF_CE_CYCLES;
				end
				if (pwdata[WDRF_EN_BIT])
				begin
					wdeNxt = 1'b1;
				end
				else if (wdceR && !level2)
				begin
					wdeNxt = 1'b0;
				end
				wdieNxt = pwdata[WDRF_IE_BIT];
				if (wdceR)
				begin
					pselNxt = {pwdata[WDRF_P3_BIT], pwdata[WDRF_P_LO_MSB:0]};
				end
				if (pwdata[WDRF_IF_BIT])
				begin
					wdifNxt = 1'b0;
				end
			end
			if (irqVectorTaken)
			begin
				wdifNxt = 1'b0;
			end
			if (irqAction)
			begin
				wdifNxt = 1'b1;
				if (wdeEff)
				begin
					wdieNxt = 1'b0;
				end
			end
		end
		if (wrRss)
		begin
			rssNxt = rssR & pwdata[3:0];
		end
		if (rstAction)
		begin
			rssNxt[WDRF_WDR_BIT] = 1'b1;
		end
		if (brownoutReset)
		begin
			rssNxt[WDRF_BOR_BIT] = 1'b1;
		end
		if (pinReset)
		begin
			rssNxt[WDRF_PIN_BIT] = 1'b1;
		end
		if (rssNxt[WDRF_WDR_BIT])
		begin
			wdeNxt = 1'b1;
		end
		if (!running || wdrStrobe || chipReset || timeout)
		begin
			cntNxt = '0;
		end
		else if (oscTick)
		begin
			cntNxt = cntR + WDRF_CNT_W'(1);
		end
	end

	// ****************************************
	// Read data.
	// ****************************************
	assign csrView = {wdifR, wdieR, pselR[3], wdceR, wdeEff, pselR[2:0]};

	always_comb
	begin
		prdataNxt = prdataR;
		if (setupPhase)
		begin
			if (hitCsr)
			begin
				prdataNxt = {24'h0, csrView};
			end
			else if (hitRss)
			begin
				prdataNxt = {28'h0, rssR};
			end
			else
			begin
				prdataNxt = '0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			wdifR <= 1'b0;
			wdieR <= 1'b0;
			wdceR <= 1'b0;
			wdeR <= 1'b0;
			ceCntR <= '0;
			pselR <= WDRF_PSEL_RESET;
			rssR <= WDRF_RSS_RESET;
			cntR <= '0;
			rstPulseR <= 1'b0;
			prdataR <= '0;
		end
		else
		begin
			wdifR <= wdifNxt;
			wdieR <= wdieNxt;
			wdceR <= wdceNxt;
			wdeR <= wdeNxt;
			ceCntR <= ceCntNxt;
			pselR <= pselNxt;
			rssR <= rssNxt;
			cntR <= cntNxt;
			rstPulseR <= rstPulseNxt;
			prdataR <= prdataNxt;
		end
	end

	// ****************************************
	// Outputs.
	// ****************************************
	assign prdata = prdataR;
	assign wdtIrqReq = globalIrqEnable & wdieR & wdifR;
	assign wdtResetPulse = rstPulseR;
	assign wdtRunning = running;

	// ****************************************
	// Checks.
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence ceArm;
		wrCsr && pwdata[WDRF_CE_BIT] && pwdata[WDRF_EN_BIT] && !chipReset;
	endsequence

	sequence ceQuiet;
		!(wrCsr && pwdata[WDRF_CE_BIT] && pwdata[WDRF_EN_BIT]) && !chipReset;
	endsequence

	chk_rss_high_zero: assert property (
		setupPhase && hitRss |=> prdata[31:4] == 28'h0)
		else $error("reset-source upper bits not zero");
	chk_wdr_flag_set: assert property (
		rstAction |=> wdtResetPulse && rssR[WDRF_WDR_BIT])
		else $error("watchdog reset flag not set");
	chk_bor_flag_set: assert property (
		brownoutReset |=> rssR[WDRF_BOR_BIT])
		else $error("brown-out flag not set");
	chk_por_flag_kept: assert property (
		rssR[WDRF_POR_BIT] && !wrRss |=> rssR[WDRF_POR_BIT])
		else $error("power-on flag lost");
	chk_irq_flag_set: assert property (
		irqAction |=> wdifR && !wdtResetPulse)
		else $error("interrupt flag not set on time-out");
	chk_vector_clear: assert property (
		irqVectorTaken && !irqAction |=> !wdifR)
		else $error("interrupt flag not cleared by vector");
	chk_irq_gate: assert property (
		irqAction && !wdeEff && !wrCsr && !chipReset |=> wdtIrqReq == globalIrqEnable)
		else $error("interrupt request not gated by global enable");
	chk_ie_drop: assert property (
		irqAction && wdeEff && !chipReset |=> !wdieR)
		else $error("interrupt enable not dropped");
	chk_ce_expire: assert property (
		ceArm ##1 ceQuiet [*4] |=> !wdceR)
		else $error("change enable did not expire after four cycles");
	chk_ce_hold: assert property (
		ceArm |=> wdceR [*4])
		else $error("change enable dropped early");
	chk_wde_kept: assert property (
		wrCsr && !pwdata[WDRF_EN_BIT] && !wdceR && !chipReset && wdeR |=> wdeR)
		else $error("enable cleared without change enable");
	chk_psel_lock: assert property (
		wrCsr && !wdceR && !chipReset |=> $stable(pselR))
		else $error("prescaler changed without change enable");
	chk_level2_run: assert property (
		safetyFuse |-> wdtRunning)
		else $error("watchdog stopped in level 2");
	chk_pulse_width: assert property (
		wdtResetPulse |=> !wdtResetPulse)
		else $error("reset pulse longer than one cycle");
	chk_restart: assert property (
		wdrStrobe |=> cntR == '0)
		else $error("count not restarted");
endmodule

//--- hw/wdrf_pkg.sv
// Constants shared by the watchdog and reset-source status block.
package wdrf_pkg;

	// ****************************************
	// Bus geometry.
	// ****************************************
	localparam int WDRF_ADDR_W = 12;
	localparam int WDRF_DATA_W = 32;

	// ****************************************
	// Register indexes and byte addresses.
	// ****************************************
	localparam logic [7:0] WDRF_CSR_IDX = 8'h21;
	localparam logic [7:0] WDRF_RSS_IDX = 8'h22;
	localparam logic [11:0] WDRF_CSR_ADDR = {2'h0, WDRF_CSR_IDX, 2'h0};
	localparam logic [11:0] WDRF_RSS_ADDR = {2'h0, WDRF_RSS_IDX, 2'h0};

	// ****************************************
	// Field positions of the watchdog control and status register.
	// ****************************************
	localparam int WDRF_IF_BIT = 7;
	localparam int WDRF_IE_BIT = 6;
	localparam int WDRF_P3_BIT = 5;
	localparam int WDRF_CE_BIT = 4;
	localparam int WDRF_EN_BIT = 3;
	localparam int WDRF_P_LO_MSB = 2;

	// ****************************************
	// Field positions of the reset-source status register.
	// ****************************************
	localparam int WDRF_WDR_BIT = 3;
	localparam int WDRF_BOR_BIT = 2;
	localparam int WDRF_PIN_BIT = 1;
	localparam int WDRF_POR_BIT = 0;

	// ****************************************
	// Reset values and limits.
	// ****************************************
	localparam logic [3:0] WDRF_RSS_RESET = 4'h1;
	localparam logic [3:0] WDRF_PSEL_RESET = 4'h0;
	localparam logic [3:0] WDRF_PSEL_MAX = 4'h9;
	localparam logic [2:0] WDRF_CE_CYCLES = 3'h4;

	// ****************************************
	// Timing: system clock and watchdog oscillator.
	// ****************************************
	localparam int WDRF_CLK_KHZ = 40000;
	localparam int WDRF_OSC_KHZ = 128;
	localparam int WDRF_BASE_TICKS = 2048;
	localparam int WDRF_CNT_W = 21;
	localparam int WDRF_ACC_W = 16;

	// ****************************************
	// Watchdog modes.
	// ****************************************
	typedef enum logic [1:0] {
		MODE_STOP,
		MODE_IRQ,
		MODE_RESET,
		MODE_IRQ_RESET
	} wdrf_mode_e;

endpackage

//--- hw/wdrf_tick_gen.sv
// Fractional divider that makes the watchdog oscillator tick enable.
`timescale 1ns/1ps
module wdrf_tick_gen
#(
	parameter int ACC_W = 16,
	parameter int STEP = 128,
	parameter int MODULUS = 40000
)
(
	input wire logic clk,
	input wire logic reset_n,
	output logic tick
);
	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] acc_nxt;
	logic tick_r;
	logic tick_nxt;
	logic [ACC_W:0] sum;

	// ****************************************
	// Adds the step each cycle and wraps at the modulus.
	// ****************************************
	always_comb
	begin
		sum = {1'b0, acc_r} + (ACC_W+1)'(STEP);
		if (sum >= (ACC_W+1)'(MODULUS))
		begin
			acc_nxt = ACC_W'(sum - (ACC_W+1)'(MODULUS));
			tick_nxt = 1'b1;
		end
		else
		begin
			acc_nxt = sum[ACC_W-1:0];
			tick_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			acc_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule

//--- dv/wdrf_watchdog_tb_top.sv
// Self-checking testbench for the watchdog and reset-source block.
`timescale 1ns/1ps
module wdrf_watchdog_tb_top;
	import wdrf_pkg::*;
	// ****************************************
	// Signals.
	// ****************************************
	localparam int BASE = 4;
	localparam logic [11:0] CSR = WDRF_CSR_ADDR;
	localparam logic [11:0] RSS = WDRF_RSS_ADDR;
	typedef struct {
		logic [11:0] a;
		logic [7:0] w;
		logic [7:0] r;
		logic e;
		logic run;
	} wdrf_row_s;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic safetyFuse = 1'b0;
	logic globalIrqEnable = 1'b0;
	logic irqVectorTaken = 1'b0;
	logic wdrStrobe = 1'b0;
	logic brownoutReset = 1'b0;
	logic pinReset = 1'b0;
	logic wdtIrqReq;
	logic wdtResetPulse;
	logic wdtRunning;
	logic [31:0] rd;
	logic err;
	int cyc;
	int miscompares = 0;
	int nTests = 0;
	wdrf_row_s rows [8];
	wdrf_watchdog #(.WDT_BASE_TICKS(BASE)) DUT (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .safetyFuse(safetyFuse),
		.globalIrqEnable(globalIrqEnable), .irqVectorTaken(irqVectorTaken),
		.wdrStrobe(wdrStrobe), .brownoutReset(brownoutReset), .pinReset(pinReset),
		.wdtIrqReq(wdtIrqReq), .wdtResetPulse(wdtResetPulse), .wdtRunning(wdtRunning));
	always #12.5 clk = ~clk;
	// ****************************************
	// Tasks.
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		nTests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string msg);
		apb(1'b0, a, 8'h00);
		chk(rd, {24'h000000, exp}, msg);
	endtask
	task automatic dis();
		apb(1'b1, CSR, 8'h18);
		apb(1'b1, CSR, 8'h00);
	endtask
	task automatic drive(input int k, input logic v);
		case (k)
			0: wdrStrobe <= v;
			1: irqVectorTaken <= v;
			2: brownoutReset <= v;
			default: pinReset <= v;
		endcase
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		drive(k, 1'b1);
		@(posedge clk);
		drive(k, 1'b0);
	endtask
	task automatic waitEvt(input int k, input int limit);
		cyc = 0;
		do
		begin
			@(negedge clk);
			cyc++;
		end
		while (cyc < limit && (k == 0 ? wdtResetPulse : wdtIrqReq) !== 1'b1);
	endtask
	task automatic period(input int k, input int ticks, input string msg);
		int lo;
		int hi;
		lo = (ticks - 1) * 625 / 2;
		hi = (ticks + 1) * 625 / 2 + 8;
		waitEvt(k, hi);
		chk({31'h0, (cyc >= lo && cyc < hi)}, 32'h1, msg);
	endtask
	task automatic test_done();
		if (miscompares == 0 && nTests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****************************************
	// Tests.
	// ****************************************
	initial
	begin
		repeat (60000) @(posedge clk);
		miscompares++;
		test_done();
	end
	initial
	begin
		rows = '{
			'{RSS, 8'h00, 8'h00, 1'b0, 1'b0},
			'{CSR, 8'h40, 8'h40, 1'b0, 1'b1},
			'{CSR, 8'h47, 8'h40, 1'b0, 1'b1},
			'{CSR, 8'h00, 8'h00, 1'b0, 1'b0},
			'{CSR, 8'h08, 8'h08, 1'b0, 1'b1},
			'{CSR, 8'h00, 8'h08, 1'b0, 1'b1},
			'{12'h090, 8'hff, 8'h00, 1'b1, 1'b1},
			'{RSS, 8'hff, 8'h00, 1'b0, 1'b1}
		};
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rdc(CSR, 8'h00, "control after reset");
		rdc(RSS, 8'h01, "flags after reset");
		chk(wdtRunning, 32'h0, "running after reset");
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].w);
			chk(pready, 32'h1, "ready");
			chk(err, rows[i].e, "write error");
			rdc(rows[i].a, rows[i].r, "row read");
			chk(err, rows[i].e, "read error");
			@(negedge clk);
			chk(wdtRunning, rows[i].run, "row running");
		end
		dis();
		rdc(CSR, 8'h00, "disable sequence");
		apb(1'b1, CSR, 8'h18);
		rdc(CSR, 8'h18, "change enable armed");
		repeat (4) @(posedge clk);
		rdc(CSR, 8'h08, "change enable expired");
		apb(1'b1, CSR, 8'h00);
		rdc(CSR, 8'h08, "late disable");
		pulse(0);
		period(0, BASE, "reset period");
		@(negedge clk);
		chk(wdtResetPulse, 32'h0, "pulse width");
		rdc(RSS, 8'h08, "watchdog flag");
		dis();
		rdc(CSR, 8'h08, "enable forced");
		period(0, BASE, "second period");
		apb(1'b1, RSS, 8'h00);
		rdc(CSR, 8'h08, "enable kept after flag clear");
		dis();
		rdc(CSR, 8'h00, "disable after flag clear");
		apb(1'b1, CSR, 8'h08);
		repeat (4)
		begin
			waitEvt(0, 900);
			chk(cyc, 900, "restart holds off reset");
			pulse(0);
		end
		apb(1'b1, CSR, 8'h18);
		apb(1'b1, CSR, 8'h29);
		repeat (4) @(posedge clk);
		rdc(CSR, 8'h29, "prescale high bit");
		apb(1'b1, CSR, 8'h18);
		apb(1'b1, CSR, 8'h09);
		pulse(0);
		period(0, 2 * BASE, "code one period");
		apb(1'b1, RSS, 8'h00);
		dis();
		@(posedge clk);
		globalIrqEnable <= 1'b1;
		apb(1'b1, CSR, 8'h40);
		pulse(0);
		period(1, BASE, "irq period");
		rdc(CSR, 8'hc0, "irq flag");
		@(posedge clk);
		globalIrqEnable <= 1'b0;
		@(negedge clk);
		chk(wdtIrqReq, 32'h0, "global mask");
		@(posedge clk);
		globalIrqEnable <= 1'b1;
		@(negedge clk);
		chk(wdtIrqReq, 32'h1, "global unmask");
		pulse(1);
		@(negedge clk);
		chk(wdtIrqReq, 32'h0, "vector clears");
		rdc(CSR, 8'h40, "flag after vector");
		period(1, BASE, "irq repeat");
		apb(1'b1, CSR, 8'hc0);
		rdc(CSR, 8'h40, "write one clears");
		rdc(RSS, 8'h00, "no reset in irq mode");
		apb(1'b1, CSR, 8'h48);
		pulse(0);
		waitEvt(0, 1700);
		chk(cyc, 1700, "first timeout interrupts");
		rdc(CSR, 8'h88, "irq enable cleared");
		waitEvt(0, 1700);
		chk({31'h0, (cyc < 1700)}, 32'h1, "second timeout resets");
		apb(1'b1, RSS, 8'h00);
		dis();
		pulse(2);
		rdc(RSS, 8'h04, "brown-out flag");
		pulse(3);
		rdc(RSS, 8'h06, "pin flag");
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rdc(RSS, 8'h01, "power-on clears flags");
		@(posedge clk);
		safetyFuse <= 1'b1;
		@(negedge clk);
		chk(wdtRunning, 32'h1, "level two running");
		dis();
		rdc(CSR, 8'h08, "level two stays on");
		test_done();
	end
endmodule
